// *** rtl/hns_map.svh ***
// Constants of the host notify sequencer: pin codes, timing counts.
// Assumes a 100 MHz core clock; included by hns_top, hns_monitor and the testbench.
`ifndef HNS_MAP_SVH
`define HNS_MAP_SVH
// Core clock period in ns
`define HNS_CLK_NS 10
// Aux pin function code selecting the power-request output
`define HNS_AUX_PWR_REQ 3'h5
// Halt value written by the core after the pulse
`define HNS_HALT_VAL 8'h04
// Power-request settle time, ms, and its cycle count
`define HNS_PWR_WAIT_MS 200
`define HNS_PWR_WAIT_CYC (`HNS_PWR_WAIT_MS * 1000000 / `HNS_CLK_NS)
// Halt timeout, ms, and its cycle count
`define HNS_HALT_TMO_MS 2048
`define HNS_HALT_TMO_CYC (`HNS_HALT_TMO_MS * 1000000 / `HNS_CLK_NS)
// Interrupt pulse widths in us, short and long
`define HNS_IRQ_SHORT_US 64
`define HNS_IRQ_LONG_US 256
`define HNS_IRQ_SHORT_CYC (`HNS_IRQ_SHORT_US * 1000 / `HNS_CLK_NS)
`define HNS_IRQ_LONG_CYC (`HNS_IRQ_LONG_US * 1000 / `HNS_CLK_NS)
`endif

// *** rtl/hns_pkg.sv ***
// Types of the host notify sequencer.
// Assumes nothing beyond the map header.
package hns_pkg;
   // One-hot sequencer states
   typedef enum logic [9:0] {
      ST_MEAS = 10'h001, // Sensor measurement
      ST_ALGO = 10'h002, // Pressure change algorithm
      ST_SLEEP = 10'h004, // Deep sleep, period filler
      ST_SELFT = 10'h008, // Self-test, outside the period
      ST_SPIEN = 10'h010, // Enable SPI client
      ST_PWRW = 10'h020, // Power request settle
      ST_PULSE = 10'h040, // Interrupt pulse
      ST_HALT = 10'h080, // Write halt register
      ST_WAIT = 10'h100, // Wait for clear or timeout
      ST_CMD = 10'h200 // Execute host commands
   } hns_state_e;
   // Counter type, wide enough for the halt timeout
   typedef logic [31:0] hns_cnt_t;
endpackage : hns_pkg

// *** rtl/hns_top.sv ***
// Sequencer for the periodic cycle and host notification handshake.
// Assumes measurement, algorithm, self-test and command units handshake by
// start pulses and done levels on the same clock; the SPI client sits outside.
//
// Contract
// - Period is measure, algorithm, then sleep
// - Self-test runs between periods, uncounted
// - Pulse interrupt, wait clear or 2048 ms
// - After host clear, run queued commands
// - Pulse width chosen by configuration bit
// - On timeout, skip commands, enter sleep
// - Power-request pin driven before pulse when selected
// - Power request then 200 ms before pulse
// - Enable SPI client before the pulse
// - Write non-zero halt value after pulse
`include "hns_map.svh"
module hns_top #(
   // Power-request settle and halt timeout; a bench may shorten both
   parameter hns_pkg::hns_cnt_t PWR_CYC = 32'(`HNS_PWR_WAIT_CYC),
   parameter hns_pkg::hns_cnt_t TMO_CYC = 32'(`HNS_HALT_TMO_CYC)
) (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic [15:0] i_sleep_cycles, // Sleep length, sets period
   input wire logic i_selftest_due, // Self-test owed before next period
   input wire logic i_event_pending, // Event needs host attention
   input wire logic i_meas_done, // Measurement unit finished
   input wire logic i_algo_done, // Change algorithm finished
   input wire logic i_selftest_done, // Self-test finished
   input wire logic i_cmd_done, // Command unit finished
   input wire logic i_irq_pulse_width_sel, // 1 selects long pulse
   input wire logic i_irq_polarity_sel, // 1 makes pulse high
   input wire logic [2:0] i_aux_pin_function_sel, // Aux pin function
   input wire logic i_halt_clear, // Host wrote zero to halt reg
   output logic o_meas_start,
   output logic o_algo_start,
   output logic o_selftest_start,
   output logic o_cmd_start,
   output logic o_deep_sleep_state,
   output logic o_spi_enable,
   output logic o_power_request_pin,
   output logic o_irq_pin,
   output logic [7:0] o_core_halt_reg,
   output logic o_timeout_flag // Last wait ended on timeout
);
   // Counts as constants of the counter width
   localparam hns_pkg::hns_cnt_t SHORT_CYC = 32'(`HNS_IRQ_SHORT_CYC);
   localparam hns_pkg::hns_cnt_t LONG_CYC = 32'(`HNS_IRQ_LONG_CYC);

   hns_pkg::hns_state_e state_q, state_d; // Sequencer state
   hns_pkg::hns_cnt_t cnt_q, cnt_d; // Shared phase counter
   logic meas_q, meas_d;
   logic algo_q, algo_d;
   logic st_q, st_d;
   logic cmd_q, cmd_d;
   logic sleep_q, sleep_d;
   logic spi_q, spi_d;
   logic pwr_q, pwr_d;
   logic irq_q, irq_d;
   logic [7:0] halt_q, halt_d;
   logic tmo_q, tmo_d;
   // Sticky latch of the host clear so a one-cycle write is never missed
   logic clr_seen_q, clr_seen_d;

   // Phase ends when the next count reaches its limit; shared by all timed phases
   function automatic logic count_done(input hns_pkg::hns_cnt_t cnt,
      input hns_pkg::hns_cnt_t lim);
      count_done = (cnt + 32'h1 >= lim);
   endfunction : count_done

   // Next-state logic of the whole sequence
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q + 32'h1;
      meas_d = 1'b0;
      algo_d = 1'b0;
      st_d = 1'b0;
      cmd_d = 1'b0;
      sleep_d = sleep_q;
      spi_d = spi_q;
      pwr_d = pwr_q;
      irq_d = ~i_irq_polarity_sel; // Idle level follows polarity
      halt_d = halt_q;
      tmo_d = tmo_q;
      clr_seen_d = clr_seen_q | i_halt_clear;
      case (state_q)
         hns_pkg::ST_MEAS:
         begin
            // Algorithm starts once measurement completes
            if (i_meas_done)
            begin
               state_d = hns_pkg::ST_ALGO;
               algo_d = 1'b1;
            end
         end
         hns_pkg::ST_ALGO:
         begin
            if (i_algo_done)
            begin
               cnt_d = 32'h0;
               if (i_event_pending)
               begin
                  state_d = hns_pkg::ST_SPIEN;
                  spi_d = 1'b1;
               end
               else
               begin
                  state_d = hns_pkg::ST_SLEEP;
                  sleep_d = 1'b1;
               end
            end
         end
         hns_pkg::ST_SLEEP:
         begin
            // Only the sleep length differs between periods
            if (count_done(cnt_q, {16'h0, i_sleep_cycles}))
            begin
               sleep_d = 1'b0;
               if (i_selftest_due)
               begin
                  state_d = hns_pkg::ST_SELFT;
                  st_d = 1'b1;
               end
               else
               begin
                  state_d = hns_pkg::ST_MEAS;
                  meas_d = 1'b1;
               end
            end
         end
         hns_pkg::ST_SELFT:
         begin
            // Self-test sits after sleep, so no period counter sees it
            if (i_selftest_done)
            begin
               state_d = hns_pkg::ST_MEAS;
               meas_d = 1'b1;
            end
         end
         hns_pkg::ST_SPIEN:
         begin
            // SPI client is on one cycle before anything else moves
            cnt_d = 32'h0;
            if (i_aux_pin_function_sel == `HNS_AUX_PWR_REQ)
            begin
               state_d = hns_pkg::ST_PWRW;
               pwr_d = 1'b1;
            end
            else
            begin
               state_d = hns_pkg::ST_PULSE;
               irq_d = i_irq_polarity_sel;
            end
         end
         hns_pkg::ST_PWRW:
         begin
            if (count_done(cnt_q, PWR_CYC))
            begin
               state_d = hns_pkg::ST_PULSE;
               cnt_d = 32'h0;
               irq_d = i_irq_polarity_sel;
            end
         end
         hns_pkg::ST_PULSE:
         begin
            irq_d = i_irq_polarity_sel;
            if (count_done(cnt_q, i_irq_pulse_width_sel ? LONG_CYC : SHORT_CYC))
            begin
               irq_d = ~i_irq_polarity_sel;
               state_d = hns_pkg::ST_HALT;
            end
         end
         hns_pkg::ST_HALT:
         begin
            // Core halts only after the line is idle, avoiding contention
            halt_d = `HNS_HALT_VAL;
            clr_seen_d = 1'b0;
            cnt_d = 32'h0;
            state_d = hns_pkg::ST_WAIT;
         end
         hns_pkg::ST_WAIT:
         begin
            if (clr_seen_q)
            begin
               // Host cleared halt in its last transfer
               halt_d = 8'h00;
               tmo_d = 1'b0;
               state_d = hns_pkg::ST_CMD;
               cmd_d = 1'b1;
            end
            // A clear arriving on the last cycle still wins over the timeout
            else if (!i_halt_clear && count_done(cnt_q, TMO_CYC))
            begin
               halt_d = 8'h00;
               tmo_d = 1'b1;
               spi_d = 1'b0;
               pwr_d = 1'b0;
               cnt_d = 32'h0;
               state_d = hns_pkg::ST_SLEEP;
               sleep_d = 1'b1;
            end
         end
         hns_pkg::ST_CMD:
         begin
            if (i_cmd_done)
            begin
               spi_d = 1'b0;
               pwr_d = 1'b0;
               cnt_d = 32'h0;
               state_d = hns_pkg::ST_SLEEP;
               sleep_d = 1'b1;
            end
         end
         default:
         begin
            state_d = hns_pkg::ST_MEAS;
            meas_d = 1'b1;
         end
      endcase
   end

   // Registers only; reset starts in sleep with the counter cleared
   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         state_q <= hns_pkg::ST_SLEEP;
         cnt_q <= 32'h0;
         meas_q <= 1'b0;
         algo_q <= 1'b0;
         st_q <= 1'b0;
         cmd_q <= 1'b0;
         sleep_q <= 1'b1;
         spi_q <= 1'b0;
         pwr_q <= 1'b0;
         irq_q <= 1'b0;
         halt_q <= 8'h00;
         tmo_q <= 1'b0;
         clr_seen_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         meas_q <= meas_d;
         algo_q <= algo_d;
         st_q <= st_d;
         cmd_q <= cmd_d;
         sleep_q <= sleep_d;
         spi_q <= spi_d;
         pwr_q <= pwr_d;
         irq_q <= irq_d;
         halt_q <= halt_d;
         tmo_q <= tmo_d;
         clr_seen_q <= clr_seen_d;
      end
   end

   // Outputs straight from flip-flops
   assign o_meas_start = meas_q;
   assign o_algo_start = algo_q;
   assign o_selftest_start = st_q;
   assign o_cmd_start = cmd_q;
   assign o_deep_sleep_state = sleep_q;
   assign o_spi_enable = spi_q;
   assign o_power_request_pin = pwr_q;
   assign o_irq_pin = irq_q;
   assign o_core_halt_reg = halt_q;
   assign o_timeout_flag = tmo_q;
endmodule : hns_top

// *** dv/hns_monitor.sv ***
// Port checker for the host notify sequencer.
// Assumes one core clock and binding onto hns_top.
`include "hns_map.svh"
module hns_monitor (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_meas_done,
   input wire logic i_irq_pulse_width_sel,
   input wire logic i_irq_polarity_sel,
   input wire logic [2:0] i_aux_pin_function_sel,
   input wire logic i_halt_clear,
   input wire logic o_algo_start,
   input wire logic o_selftest_start,
   input wire logic o_cmd_start,
   input wire logic o_deep_sleep_state,
   input wire logic o_spi_enable,
   input wire logic o_power_request_pin,
   input wire logic o_irq_pin,
   input wire logic [7:0] o_core_halt_reg,
   input wire logic o_timeout_flag
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   logic act; // Pulse active while notifying
   logic [31:0] w_q, w_d; // Pulse length so far
   assign act = o_spi_enable && (o_irq_pin == i_irq_polarity_sel);
   // Spi gate keeps a reset-time low from counting as a pulse
   always_comb w_d = act ? w_q + 32'h1 : 32'h0;
   always_ff @(posedge i_core_clk or negedge i_resetn)
      if (!i_resetn) w_q <= 32'h0;
      else w_q <= w_d;
   algo_after_meas_a: assert property (o_algo_start |-> $past(i_meas_done))
      else $error("algorithm began without measurement");
   selft_off_period_a: assert property (o_selftest_start |-> $past(o_deep_sleep_state))
      else $error("self-test not between periods");
   spi_before_irq_a: assert property (act && !$stable(o_irq_pin) |-> $past(o_spi_enable))
      else $error("pulse before spi enable");
   pulse_width_a: assert property ($fell(act) |-> w_q == (i_irq_pulse_width_sel ?
      `HNS_IRQ_LONG_CYC : `HNS_IRQ_SHORT_CYC))
      else $error("pulse width wrong");
   halt_after_pulse_a: assert property ($fell(act) |-> ##[0:1] o_core_halt_reg == `HNS_HALT_VAL)
      else $error("halt not written after pulse");
   halt_idle_a: assert property (o_core_halt_reg != 8'h00 |-> o_irq_pin != i_irq_polarity_sel)
      else $error("halted while line active");
   // Clear is latched first, then the state steps: two edges to commands
   clear_runs_cmd_a: assert property (o_core_halt_reg != 8'h00 && i_halt_clear |-> ##2
      o_cmd_start && o_core_halt_reg == 8'h00)
      else $error("clear did not start commands");
   tmo_to_sleep_a: assert property ($rose(o_timeout_flag) |-> o_deep_sleep_state &&
      !o_spi_enable && !o_power_request_pin && o_core_halt_reg == 8'h00)
      else $error("timeout did not go to sleep");
   cmd_no_tmo_a: assert property (o_cmd_start |-> !o_timeout_flag)
      else $error("commands after timeout");
   pwr_before_irq_a: assert property (act && i_aux_pin_function_sel == `HNS_AUX_PWR_REQ |->
      o_power_request_pin)
      else $error("power request missing");
endmodule : hns_monitor
bind hns_top hns_monitor i_mon (.*);

// *** dv/hns_host_model.sv ***
// Host controller model: waits for the idle line, then clears the halt.
// Assumes the sequencer ports on the core clock; lag sets its speed.
module hns_host_model (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_irq_pin,
   input wire logic i_irq_polarity_sel,
   input wire logic [7:0] i_core_halt_reg,
   input wire logic [7:0] i_lag,
   output logic o_halt_clear
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt; // Cycles spent halted with idle line
   // Transfers start only once the pulse is over
   always @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         cnt <= 0;
         o_halt_clear <= 1'b0;
      end
      else if (i_core_halt_reg != 8'h00 && i_irq_pin != i_irq_polarity_sel)
      begin
         cnt <= cnt + 1;
         o_halt_clear <= #1 (cnt == int'(i_lag));
      end
      else
      begin
         cnt <= 0;
         o_halt_clear <= #1 1'b0;
      end
   end
endmodule : hns_host_model

// *** dv/host_notify_sequencer_tb_top.sv ***
// Testbench of the host notify sequencer with a host model.
// Assumes hns_top, hns_host_model and the bound checker.
`include "hns_map.svh"
module host_notify_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic i_core_clk = 1'b0, i_resetn = 1'b0, i_halt_clear;
   logic [15:0] i_sleep_cycles = 16'h000c;
   logic i_selftest_due = 1'b0, i_event_pending = 1'b0, i_irq_pulse_width_sel = 1'b0;
   logic i_meas_done = 1'b0, i_algo_done = 1'b0, i_selftest_done = 1'b0, i_cmd_done = 1'b0;
   logic i_irq_polarity_sel = 1'b1;
   logic [2:0] i_aux_pin_function_sel = 3'h0;
   logic [7:0] lag = 8'h00, o_core_halt_reg;
   logic o_meas_start, o_algo_start, o_selftest_start, o_cmd_start, o_deep_sleep_state;
   logic o_spi_enable, o_power_request_pin, o_irq_pin, o_timeout_flag;
   int error_cnt = 0, num_checks = 0, cyc = 0, w, p, seen;
   // Short settle and timeout counts keep both paths inside the run budget
   localparam int PWR = 50;
   localparam int TMO = 200;
   hns_top #(.PWR_CYC(32'(PWR)), .TMO_CYC(32'(TMO))) i_dut (.*);
   hns_host_model i_host (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_irq_pin(o_irq_pin),
      .i_irq_polarity_sel(i_irq_polarity_sel), .i_core_halt_reg(o_core_halt_reg),
      .i_lag(lag), .o_halt_clear(i_halt_clear));
   always #5 i_core_clk = ~i_core_clk;
   // Phase units finish one cycle after their start
   always @(posedge i_core_clk)
   begin
      i_meas_done <= #1 o_meas_start;
      i_algo_done <= #1 o_algo_start;
      i_selftest_done <= #1 o_selftest_start;
      i_cmd_done <= #1 o_cmd_start;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask : chk
   task automatic results();
      if (error_cnt == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results
   task automatic tick();
      @(posedge i_core_clk);
      #1;
   endtask : tick
   // Hang guard, well above four pulses and their waits
   always @(posedge i_core_clk)
   begin
      cyc++;
      if (cyc == 100000)
      begin
         error_cnt++;
         results();
      end
   end
   initial
   begin
      void'($urandom(68674));
      repeat (2) tick();
      i_resetn = 1'b1;
      for (int r = 0; r < 6; r++)
      begin
         while (!o_deep_sleep_state) tick();
         chk(o_spi_enable, 1'b0, "spi still enabled in sleep");
         chk(o_power_request_pin, 1'b0, "power request left on");
         // Long sleeps leave room to set the next period up
         i_event_pending = (r < 4);
         i_irq_pulse_width_sel = r[0];
         i_irq_polarity_sel = 1'($urandom_range(1));
         i_selftest_due = 1'($urandom_range(1));
         i_sleep_cycles = 16'($urandom_range(30, 8));
         i_aux_pin_function_sel = r[1] ? `HNS_AUX_PWR_REQ : 3'($urandom_range(4));
         // The fourth event goes unanswered so the wait runs out
         lag = (r == 3) ? 8'hff : 8'($urandom_range(40));
         while (!o_meas_start && !o_selftest_start) tick();
         chk(o_selftest_start, i_selftest_due, "self-test order");
         i_selftest_due = 1'b0;
         while (!o_algo_start) tick();
         while (!o_spi_enable && !o_deep_sleep_state) tick();
         chk(o_spi_enable, i_event_pending, "notify decision");
         if (i_event_pending)
         begin
            i_event_pending = 1'b0;
            w = 0;
            p = 0;
            while (o_irq_pin !== i_irq_polarity_sel)
            begin
               p += int'(o_power_request_pin);
               tick();
            end
            chk(p, (i_aux_pin_function_sel == `HNS_AUX_PWR_REQ) ? PWR : 0, "power wait");
            while (o_irq_pin === i_irq_polarity_sel)
            begin
               w++;
               tick();
            end
            chk(w, r[0] ? `HNS_IRQ_LONG_CYC : `HNS_IRQ_SHORT_CYC, "pulse width");
            tick();
            chk(o_core_halt_reg, `HNS_HALT_VAL, "halt value");
            if (r == 3)
            begin
               // Unanswered wait: bounded, then straight to sleep, no commands
               w = 0;
               seen = 0;
               while (!o_deep_sleep_state)
               begin
                  w++;
                  seen += int'(o_cmd_start);
                  tick();
               end
               chk(w, TMO, "timeout length");
               chk(seen, 0, "commands ran after timeout");
               chk(o_timeout_flag, 1'b1, "timeout not flagged");
               chk(o_core_halt_reg, 8'h00, "halt kept after timeout");
            end
            else
            begin
               while (!o_cmd_start) tick();
               chk(o_core_halt_reg, 8'h00, "halt not released");
               chk(o_timeout_flag, 1'b0, "timeout flag");
            end
         end
      end
      results();
   end
endmodule : host_notify_sequencer_tb_top
